// ---- inc/timer_pair_defs.svh ----
// Offsets, field positions, reset values and timing counts of the timer pair common control
`ifndef TIMER_PAIR_DEFS_SVH
`define TIMER_PAIR_DEFS_SVH

`define TCC_ADDR 8'h01
`define TCC_RESET 8'h00
`define TCC_MODE_BIT 7
`define TCC_ROUTE_BIT 6
`define TCC_EDGE_HI 5
`define TCC_EDGE_LO 4
`define TCC_OUT_HI 3
`define TCC_OUT_LO 2
`define TCC_NARROW_BIT 1
`define TCC_WIDE_BIT 0
`define NARROW_START 8'hFF
`define FILT_SHORT_CYCLES 4
`define FILT_LONG_CYCLES 8

`endif

// ---- inc/timer_pair_pkg.sv ----
// Field encodings and state types of the timer pair common control
package timer_pair_pkg;

	typedef enum logic [1:0] {
		OUT_NORMAL = 2'h0,
		OUT_PING_PONG = 2'h1,
		OUT_FORCE_LOW = 2'h2,
		OUT_FORCE_HIGH = 2'h3
	} out_mode_t;

	typedef enum logic [1:0] {
		FILT_NONE = 2'h0,
		FILT_SHORT = 2'h1,
		FILT_LONG = 2'h2,
		FILT_RESERVED = 2'h3
	} filter_sel_t;

	typedef enum logic [1:0] {
		LOGIC_AND = 2'h0,
		LOGIC_OR = 2'h1,
		LOGIC_NOR = 2'h2,
		LOGIC_NAND = 2'h3
	} logic_fn_t;

	typedef enum logic [1:0] {
		EDGE_FALL = 2'h0,
		EDGE_RISE = 2'h1,
		EDGE_BOTH = 2'h2,
		EDGE_RESERVED = 2'h3
	} edge_sel_t;

	typedef struct packed {
		logic clean;
		logic [3:0] count;
	} filter_state_t;

	typedef struct packed {
		logic [7:0] ctrl;
		logic rise_flag;
		logic fall_flag;
		logic [7:0] rd_data;
		logic prim_meta;
		logic prim_sync;
		logic alt_meta;
		logic alt_sync;
		logic filt_prev;
		logic counting;
		logic [7:0] narrow_count;
		logic [7:0] cap_rise;
		logic [7:0] cap_fall;
		logic cap_strobe;
		logic ping_pong;
		logic wide_out;
		logic pin_out;
	} ctrl_state_t;

endpackage

// ---- inc/demod_filter_if.sv ----
// Carrier between the control block and its demodulator noise filter
`timescale 1ns/1ps
interface demod_filter_if;
	logic raw;
	logic [1:0] length_sel;
	logic clean;

	modport host (output raw, output length_sel, input clean);
	modport filter (input raw, input length_sel, output clean);
endinterface

// ---- core/demod_input_filter.sv ----
// Noise filter on the selected demodulator input
`timescale 1ns/1ps
`include "timer_pair_defs.svh"
module demod_input_filter #(
	parameter int SHORT_CYCLES = `FILT_SHORT_CYCLES,
	parameter int LONG_CYCLES = `FILT_LONG_CYCLES
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// Link to the control block
	demod_filter_if.filter flt
);

	timer_pair_pkg::filter_state_t st;
	timer_pair_pkg::filter_state_t next_st;
	logic [3:0] limit;

	always_comb begin
		next_st = st;
		limit = 4'h0;
		case (timer_pair_pkg::filter_sel_t'(flt.length_sel))
			timer_pair_pkg::FILT_SHORT: limit = 4'(SHORT_CYCLES - 1);
			timer_pair_pkg::FILT_LONG: limit = 4'(LONG_CYCLES - 1);
			default: limit = 4'h0;
		endcase
		// Level must hold for the whole window before it is accepted
		if (flt.raw == st.clean) begin
			next_st.count = 4'h0;
		end else if (st.count >= limit) begin
			next_st.clean = flt.raw;
			next_st.count = 4'h0;
		end else begin
			next_st.count = st.count + 4'h1;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign flt.clean = st.clean;

endmodule

// ---- core/timer_pair_common_control.sv ----
// Common control of the narrow and wide counters: modes, output logic and demodulation
`timescale 1ns/1ps
`include "timer_pair_defs.svh"
module timer_pair_common_control (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// Register file access
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	// Counter outputs before shaping
	input wire logic narrow_counter_output,
	input wire logic wide_counter_raw,
	input wire logic narrow_counter_enable,
	// Port data used when the pin is an ordinary output
	input wire logic port_output_data,
	// Demodulator input pins
	input wire logic demod_input_pin_primary,
	input wire logic demod_input_pin_alternate,
	// Settings handed to the counters
	output logic wide_start_level,
	output logic narrow_start_level,
	output logic ping_pong_mode,
	output logic demod_mode,
	// Shaped outputs
	output logic wide_counter_output,
	output logic timer_output_pin,
	// Demodulation results
	output logic rise_edge_flag,
	output logic fall_edge_flag,
	output logic [7:0] narrow_count,
	output logic [7:0] capture_rise,
	output logic [7:0] capture_fall,
	output logic capture_strobe
);

	timer_pair_pkg::ctrl_state_t st;
	timer_pair_pkg::ctrl_state_t next_st;

	demod_filter_if flt ();

	demod_input_filter #(
		.SHORT_CYCLES(`FILT_SHORT_CYCLES),
		.LONG_CYCLES(`FILT_LONG_CYCLES)
	) u_filter (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.flt(flt.filter)
	);

	////////////////////////////////////////////////////////////////////////////////////////////
	// Field decode

	logic is_demod;
	logic reg_hit;
	logic edge_rise;
	logic edge_fall;
	logic hit_rise;
	logic hit_fall;
	logic wide_eff;
	logic combined;
	timer_pair_pkg::edge_sel_t edge_sel;
	timer_pair_pkg::logic_fn_t logic_fn;
	timer_pair_pkg::out_mode_t out_mode;

	assign is_demod = st.ctrl[`TCC_MODE_BIT];
	assign edge_sel = timer_pair_pkg::edge_sel_t'(st.ctrl[`TCC_EDGE_HI:`TCC_EDGE_LO]);
	assign logic_fn = timer_pair_pkg::logic_fn_t'(st.ctrl[`TCC_EDGE_HI:`TCC_EDGE_LO]);
	assign out_mode = timer_pair_pkg::out_mode_t'(st.ctrl[`TCC_OUT_HI:`TCC_OUT_LO]);
	assign reg_hit = reg_wr && (reg_addr == `TCC_ADDR);

	// Source pin choice and filter length
	assign flt.raw = st.ctrl[`TCC_ROUTE_BIT] ? st.alt_sync : st.prim_sync;
	assign flt.length_sel = is_demod ? st.ctrl[`TCC_OUT_HI:`TCC_OUT_LO] : 2'h0;

	assign edge_rise = flt.clean && !st.filt_prev;
	assign edge_fall = !flt.clean && st.filt_prev;
	// Reserved edge code detects nothing
	assign hit_rise = is_demod && edge_rise &&
		(edge_sel == timer_pair_pkg::EDGE_RISE || edge_sel == timer_pair_pkg::EDGE_BOTH);
	assign hit_fall = is_demod && edge_fall &&
		(edge_sel == timer_pair_pkg::EDGE_FALL || edge_sel == timer_pair_pkg::EDGE_BOTH);

	////////////////////////////////////////////////////////////////////////////////////////////
	// Transmit output shaping

	always_comb begin
		case (out_mode)
			timer_pair_pkg::OUT_FORCE_LOW: wide_eff = 1'b0;
			timer_pair_pkg::OUT_FORCE_HIGH: wide_eff = 1'b1;
			default: wide_eff = wide_counter_raw;
		endcase
		case (logic_fn)
			timer_pair_pkg::LOGIC_AND: combined = narrow_counter_output & wide_eff;
			timer_pair_pkg::LOGIC_OR: combined = narrow_counter_output | wide_eff;
			timer_pair_pkg::LOGIC_NOR: combined = ~(narrow_counter_output | wide_eff);
			timer_pair_pkg::LOGIC_NAND: combined = ~(narrow_counter_output & wide_eff);
			default: combined = 1'b0;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		next_st = st;
		next_st.prim_meta = demod_input_pin_primary;
		next_st.prim_sync = st.prim_meta;
		next_st.alt_meta = demod_input_pin_alternate;
		next_st.alt_sync = st.alt_meta;
		next_st.filt_prev = flt.clean;
		next_st.cap_strobe = 1'b0;

		// Register write; in demodulation the low two bits are clear-on-one flags
		if (reg_hit) begin
			if (is_demod) begin
				next_st.ctrl[7:2] = reg_wdata[7:2];
				if (reg_wdata[`TCC_NARROW_BIT]) begin
					next_st.rise_flag = 1'b0;
				end
				if (reg_wdata[`TCC_WIDE_BIT]) begin
					next_st.fall_flag = 1'b0;
				end
			end else begin
				next_st.ctrl = reg_wdata;
			end
		end
		// An edge in the cycle of a clear still sets the flag
		if (hit_rise) begin
			next_st.rise_flag = 1'b1;
		end
		if (hit_fall) begin
			next_st.fall_flag = 1'b1;
		end

		// Narrow counter in demodulation
		if (!is_demod || !narrow_counter_enable) begin
			next_st.counting = 1'b0;
		end else if (hit_rise || hit_fall) begin
			if (!st.counting) begin
				next_st.counting = 1'b1;
				next_st.narrow_count = `NARROW_START;
			end else begin
				next_st.narrow_count = st.narrow_count - 8'h01;
				next_st.cap_strobe = 1'b1;
				if (hit_rise) begin
					next_st.cap_rise = ~st.narrow_count;
				end else begin
					next_st.cap_fall = ~st.narrow_count;
				end
			end
		end else if (st.counting) begin
			next_st.narrow_count = st.narrow_count - 8'h01;
		end

		// Transmit shaping; in demodulation the pin is an ordinary port output
		next_st.ping_pong = !is_demod && (out_mode == timer_pair_pkg::OUT_PING_PONG);
		next_st.wide_out = is_demod ? wide_counter_raw : wide_eff;
		if (!is_demod && st.ctrl[`TCC_ROUTE_BIT]) begin
			next_st.pin_out = combined;
		end else begin
			next_st.pin_out = port_output_data;
		end

		// Read data, one cycle behind the address
		if (reg_addr == `TCC_ADDR) begin
			next_st.rd_data = st.ctrl;
			if (is_demod) begin
				next_st.rd_data[`TCC_NARROW_BIT] = st.rise_flag;
				next_st.rd_data[`TCC_WIDE_BIT] = st.fall_flag;
			end
		end else begin
			next_st.rd_data = 8'h00;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////////
	// Outputs

	assign reg_rdata = st.rd_data;
	assign wide_start_level = st.ctrl[`TCC_WIDE_BIT];
	assign narrow_start_level = st.ctrl[`TCC_NARROW_BIT];
	assign ping_pong_mode = st.ping_pong;
	assign demod_mode = st.ctrl[`TCC_MODE_BIT];
	assign wide_counter_output = st.wide_out;
	assign timer_output_pin = st.pin_out;
	assign rise_edge_flag = st.rise_flag;
	assign fall_edge_flag = st.fall_flag;
	assign narrow_count = st.narrow_count;
	assign capture_rise = st.cap_rise;
	assign capture_fall = st.cap_fall;
	assign capture_strobe = st.cap_strobe;

endmodule

// ---- dv/timer_pair_common_control_sva.sv ----
// Concurrent checks on the ports of the timer pair common control
`timescale 1ns/1ps
module timer_pair_common_control_sva (
	// Clock, reset and register access
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	// Watched results
	input wire logic port_output_data,
	input wire logic wide_start_level,
	input wire logic narrow_start_level,
	input wire logic ping_pong_mode,
	input wire logic demod_mode,
	input wire logic wide_counter_output,
	input wire logic timer_output_pin,
	input wire logic rise_edge_flag,
	input wire logic fall_edge_flag,
	input wire logic [7:0] narrow_count,
	input wire logic capture_strobe,
	input wire logic [7:0] capture_rise,
	input wire logic [7:0] capture_fall
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	sequence s_wr;
		reg_wr && reg_addr == 8'h01;
	endsequence
	sequence s_tx_wr;
		s_wr ##0 !demod_mode && !reg_wdata[7];
	endsequence
	// A forced level only settles once no second write overtakes it
	sequence s_force;
		s_tx_wr ##0 reg_wdata[3] ##1 !reg_wr;
	endsequence
	a_mode_write: assert property (s_wr |=> demod_mode == $past(reg_wdata[7]))
		else $error("mode bit not taken");
	a_start_write: assert property (
		s_tx_wr |=> wide_start_level == $past(reg_wdata[0]) &&
		narrow_start_level == $past(reg_wdata[1]))
		else $error("start levels not taken");
	a_force_wide: assert property (
		s_force |=> wide_counter_output == $past(reg_wdata[2], 2))
		else $error("forced wide level wrong");
	// Ping-pong is registered from the mode of the previous cycle
	a_pp_transmit: assert property (ping_pong_mode |-> !$past(demod_mode))
		else $error("ping-pong outside transmit");
	a_pin_port: assert property (
		demod_mode && $past(demod_mode) |-> timer_output_pin == $past(port_output_data))
		else $error("pin not port data");
	a_capture_val: assert property (
		capture_strobe |-> capture_rise == ~$past(narrow_count) ||
		capture_fall == ~$past(narrow_count))
		else $error("capture not complement");
	a_keep_flags: assert property (
		s_wr ##0 demod_mode && reg_wdata[1:0] == 2'h0 |=>
		!$fell(rise_edge_flag) && !$fell(fall_edge_flag))
		else $error("zero write cleared flag");
	// A flag is set from the mode in force during the cycle before it shows
	a_flag_demod: assert property (
		$rose(rise_edge_flag) || $rose(fall_edge_flag) |-> $past(demod_mode))
		else $error("flag set in transmit");
	a_unmapped_zero: assert property (reg_addr != 8'h01 |=> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
endmodule
bind timer_pair_common_control timer_pair_common_control_sva timer_pair_common_control_sva_inst (
	.sys_clk, .rst_n, .reg_addr, .reg_wr, .reg_wdata, .reg_rdata, .port_output_data,
	.wide_start_level, .narrow_start_level, .ping_pong_mode, .demod_mode, .wide_counter_output,
	.timer_output_pin, .rise_edge_flag, .fall_edge_flag, .narrow_count, .capture_strobe,
	.capture_rise, .capture_fall);

// ---- dv/demod_pin_model.sv ----
// Far-side demodulator pins: the chosen pin follows the bench, the other chatters
`timescale 1ns/1ps
module demod_pin_model (
	// Clock and requested level
	input wire logic sys_clk,
	input wire logic use_alt,
	input wire logic level,
	// Pins
	output logic demod_input_pin_primary,
	output logic demod_input_pin_alternate
);
	logic noise = 1'b0;
	// A quiet unused pin would hide a wrong input selection
	always @(posedge sys_clk) noise <= ~noise;
	assign demod_input_pin_primary = use_alt ? noise : level;
	assign demod_input_pin_alternate = use_alt ? level : noise;
endmodule

// ---- dv/timer_pair_common_control_tb_top.sv ----
// Self-checking bench of the timer pair common control
`timescale 1ns/1ps
module timer_pair_common_control_tb_top;
	logic sys_clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, use_alt = 1'b0, level = 1'b0;
	logic narrow_counter_output = 1'b0, wide_counter_raw = 1'b0, narrow_counter_enable = 1'b0;
	logic port_output_data = 1'b0, demod_input_pin_primary, demod_input_pin_alternate;
	logic wide_start_level, narrow_start_level, ping_pong_mode, demod_mode, wide_counter_output;
	logic timer_output_pin, rise_edge_flag, fall_edge_flag, capture_strobe, w, c;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, narrow_count, capture_rise;
	logic [7:0] capture_fall, v;
	logic [31:0] seed = 32'h041E5B51;
	int err_total = 0, samples_checked = 0;

	always #25 sys_clk = ~sys_clk;

	timer_pair_common_control timer_pair_common_control_inst (.sys_clk, .rst_n, .reg_addr,
		.reg_wr, .reg_wdata, .reg_rdata, .narrow_counter_output, .wide_counter_raw,
		.narrow_counter_enable, .port_output_data, .demod_input_pin_primary,
		.demod_input_pin_alternate, .wide_start_level, .narrow_start_level, .ping_pong_mode,
		.demod_mode, .wide_counter_output, .timer_output_pin, .rise_edge_flag, .fall_edge_flag,
		.narrow_count, .capture_rise, .capture_fall, .capture_strobe);
	demod_pin_model demod_pin_model_inst (.sys_clk, .use_alt, .level, .demod_input_pin_primary,
		.demod_input_pin_alternate);
	//////////////////////////////////////////////////
	function automatic void step();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
	endfunction
	task automatic check(input logic [7:0] seen, input logic [7:0] want);
		samples_checked++;
		if (seen !== want) begin
			err_total++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
		#2;
	endtask
	task automatic wr(input logic [7:0] d);
		reg_addr = 8'h01;
		reg_wdata = d;
		reg_wr = 1'b1;
		tick(1);
		reg_wr = 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] want);
		reg_addr = a;
		tick(2);
		check(reg_rdata, want);
	endtask
	// One pulse on the chosen pin, then flag read, harmless write and clearing write
	task automatic demod(input logic [7:0] cfg, input int len, input logic ok);
		logic r, f;
		r = ok && cfg[5:4] inside {2'h1, 2'h2};
		f = ok && cfg[5:4] inside {2'h0, 2'h2};
		use_alt = cfg[6];
		wr(cfg);
		tick(12);
		wr(cfg | 8'h03);
		level = 1'b1;
		tick(len);
		level = 1'b0;
		tick(30);
		rd(8'h01, {cfg[7:2], r, f});
		check(rise_edge_flag, r);
		check(fall_edge_flag, f);
		wr(cfg);
		rd(8'h01, {cfg[7:2], r, f});
		wr(cfg | 8'h03);
		rd(8'h01, cfg & 8'hFC);
		check(rise_edge_flag, 1'b0);
		check(fall_edge_flag, 1'b0);
	endtask
	task automatic summarize();
		$display("checked %0d, mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	//////////////////////////////////////////////////
	initial begin
		repeat (100000) @(posedge sys_clk);
		err_total++;
		summarize();
	end
	initial begin
		tick(4);
		rst_n = 1'b1;
		rd(8'h01, 8'h00);
		rd(8'h02, 8'h00);
		for (int i = 0; i < 8; i++) begin
			step();
			v = {1'b0, seed[6:0]};
			wr(v);
			rd(8'h01, v);
			check(wide_start_level, v[0]);
			check(narrow_start_level, v[1]);
			check(ping_pong_mode, v[3:2] == 2'h1);
		end
		for (int e = 0; e < 16; e++) begin
			if (e[1:0] == 2'h1) continue;
			step();
			{narrow_counter_output, wide_counter_raw, port_output_data} = seed[2:0];
			wr({1'b0, seed[3], e[3:2], e[1:0], 2'h0});
			tick(3);
			w = e[1] ? e[0] : wide_counter_raw;
			c = (e[3] ^ e[2]) ? (narrow_counter_output | w) : (narrow_counter_output & w);
			check(wide_counter_output, w);
			check(timer_output_pin, seed[3] ? c ^ e[3] : port_output_data);
		end
		wr(8'h80);
		check(demod_mode, 1'b1);
		narrow_counter_enable = 1'b1;
		demod(8'hA0, 20, 1'b1);
		check(capture_fall, 8'h13);
		narrow_counter_enable = 1'b0;
		for (int e = 0; e < 4; e++) demod({1'b1, e[0], e[1:0], 4'h0}, 5, 1'b1);
		for (int e = 0; e < 6; e++) demod({4'h9, e[2:1] + 2'h1, 2'h0}, e[0] ? 6 : 3,
			e > 3 || e == 1);
		summarize();
	end
endmodule
